// File: logic/ugr_glyph_ram.sv
// top: user glyph pattern store, address counter and scan fetch
`timescale 1ns/100ps
module ugr_glyph_ram #(
   parameter int addr_w = ugr_pkg::ugr_addr_w,
   parameter int data_w = ugr_pkg::ugr_data_w
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic glyph_address_load,
   input wire logic [5:0] glyph_addr_in,
   input wire logic text_address_load,
   input wire logic [6:0] text_addr_in,
   input wire logic two_line_mode,
   input wire logic entry_increment,
   input wire logic write_data,
   input wire logic [data_w-1:0] write_byte,
   input wire logic read_data,
   input wire logic busy_and_address_read,
   output logic busy_flag,
   output logic [addr_w-1:0] address_counter,
   output logic [data_w-1:0] read_byte,
   output logic read_valid,
   input wire logic icon_enable,
   input wire logic icon_blink,
   output logic [4:0] icon_slots_used,
   input wire logic scan_req,
   input wire logic [7:0] scan_code,
   input wire logic [ugr_pkg::ugr_line_w-1:0] scan_line,
   input wire logic cursor_on,
   output logic scan_is_user,
   output logic [ugr_pkg::ugr_pix_w-1:0] scan_pixels,
   output logic scan_valid
);
   import ugr_pkg::*;

   // ----------------------------------------
   // instruction acceptance
   // ----------------------------------------
   ugr_state_e state;
   ugr_state_e next_state;
   logic [4:0] busy_cnt;
   logic [data_w-1:0] mem_rd;
   wire idle = (state == ugr_idle);
   // dropped while busy so a stray command cannot corrupt the counter
   wire take_glyph = idle && glyph_address_load;
   wire take_text = idle && text_address_load && !glyph_address_load;
   wire take_write = idle && write_data && !glyph_address_load && !text_address_load;
   wire take_read = idle && read_data && !write_data && !glyph_address_load && !text_address_load;
   wire text_valid = two_line_mode ?
      ((text_addr_in <= ugr_text_addr_lo2_max) ||
       ((text_addr_in >= ugr_text_addr_hi2_min) && (text_addr_in <= ugr_text_addr_hi2_max))) :
      (text_addr_in <= ugr_text_addr_max_1line);
   wire take_any = take_glyph || take_text || take_write || take_read;

   // ----------------------------------------
   // address counter
   // ----------------------------------------
   wire [addr_w-1:0] step_addr = entry_increment ? address_counter + 7'h01 : address_counter - 7'h01;
   logic [addr_w-1:0] next_addr;
   always_comb begin
      next_addr = address_counter;
      if (take_glyph) begin
         next_addr = {address_counter[6], glyph_addr_in};
      end else if (take_text && text_valid) begin
         next_addr = text_addr_in;
      end else if (take_write || take_read) begin
         next_addr = step_addr;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         address_counter <= ugr_addr_rst;
      end else begin
         address_counter <= next_addr;
      end
   end

   // ----------------------------------------
   // busy sequencing
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ugr_idle: begin
            if (take_read) begin
               next_state = ugr_rdwait;
            end else if (take_any) begin
               next_state = ugr_exec;
            end
         end
         ugr_rdwait: begin
            next_state = ugr_exec;
         end
         ugr_exec: begin
            if (busy_cnt == 5'h00) begin
               next_state = ugr_idle;
            end
         end
         default: begin
            next_state = ugr_idle;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ugr_idle;
         busy_cnt <= 5'h00;
      end else begin
         state <= next_state;
         if (take_any) begin
            busy_cnt <= ugr_busy_cycles - 5'h01;
         end else if (busy_cnt != 5'h00 && state == ugr_exec) begin
            busy_cnt <= busy_cnt - 5'h01;
         end
      end
   end

   // busy_flag and address counter always readable, even mid-instruction
   assign busy_flag = !idle;

   // ----------------------------------------
   // pattern memory, host port has priority over scan
   // ----------------------------------------
   // write wins the port; a user-glyph scan fetch colliding with it is dropped and gives no scan_valid
   wire [addr_w-1:0] scan_addr = {scan_code[3:0], scan_line};
   wire scan_user = (scan_code[7:4] == 4'h0);
   wire mem_rd_en = take_read || (scan_req && scan_user && !take_write);
   wire [addr_w-1:0] mem_rd_addr = take_read ? address_counter : scan_addr;
   logic scan_pend;
   logic read_pend;
   logic [ugr_line_w-1:0] scan_line_q;
   logic scan_user_q;
   logic cursor_q;

   ugr_pattern_mem #(
      .addr_w(addr_w),
      .data_w(data_w)
   ) u_mem (
      .clk(clk),
      .wr_en(take_write),
      .wr_addr(address_counter),
      .wr_data(write_byte),
      .rd_en(mem_rd_en),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scan_pend <= 1'b0;
         read_pend <= 1'b0;
         scan_line_q <= 3'h0;
         scan_user_q <= 1'b0;
         cursor_q <= 1'b0;
      end else begin
         scan_pend <= scan_req && !take_read && !(scan_user && take_write);
         read_pend <= take_read;
         scan_line_q <= scan_line;
         scan_user_q <= scan_user;
         cursor_q <= cursor_on;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   wire cursor_hit = cursor_q && (scan_line_q == ugr_cursor_line);
   wire [ugr_pix_w-1:0] user_pix = scan_user_q ? mem_rd[ugr_pix_w-1:0] : 5'h00;
   wire [4:0] next_slots = !icon_enable ? 5'(ugr_icon_slots_none) :
      (icon_blink ? 5'(ugr_icon_slots_blink) : 5'(ugr_icon_slots_steady));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scan_pixels <= 5'h00;
         scan_valid <= 1'b0;
         scan_is_user <= 1'b0;
         read_byte <= ugr_data_rst;
         read_valid <= 1'b0;
         icon_slots_used <= 5'h00;
      end else begin
         scan_valid <= scan_pend;
         scan_is_user <= scan_pend && scan_user_q;
         if (scan_pend) begin
            scan_pixels <= user_pix | {ugr_pix_w{cursor_hit}};
         end
         read_valid <= read_pend;
         if (read_pend) begin
            read_byte <= mem_rd;
         end
         icon_slots_used <= next_slots;
      end
   end

   // busy_and_address_read is answered combinationally from busy_flag/address_counter
   wire unused_bar = busy_and_address_read;
endmodule // ugr_glyph_ram

// File: logic/ugr_pattern_mem.sv
// memory: glyph pattern ram with registered read port
`timescale 1ns/100ps
module ugr_pattern_mem #(
   parameter int addr_w = 7,
   parameter int data_w = 8
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [addr_w-1:0] wr_addr,
   input wire logic [data_w-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [addr_w-1:0] rd_addr,
   output logic [data_w-1:0] rd_data
);
   logic [data_w-1:0] mem [0:(1<<addr_w)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // ugr_pattern_mem

// File: logic/ugr_pkg.sv
// package: constants for the user glyph pattern store
package ugr_pkg;
   localparam int ugr_glyph_slots = 16;
   localparam int ugr_addr_w = 7;
   localparam int ugr_data_w = 8;
   localparam int ugr_pix_w = 5;
   localparam int ugr_line_w = 3;
   localparam int ugr_icon_slots_blink = 8;
   localparam int ugr_icon_slots_steady = 4;
   localparam int ugr_icon_slots_none = 0;
   localparam logic [ugr_line_w-1:0] ugr_cursor_line = 3'h7;
   localparam logic [ugr_addr_w-1:0] ugr_addr_rst = 7'h00;
   localparam logic [ugr_data_w-1:0] ugr_data_rst = 8'h00;
   localparam logic [6:0] ugr_text_addr_max_1line = 7'h4f;
   localparam logic [6:0] ugr_text_addr_lo2_max = 7'h27;
   localparam logic [6:0] ugr_text_addr_hi2_min = 7'h40;
   localparam logic [6:0] ugr_text_addr_hi2_max = 7'h67;
   localparam logic [4:0] ugr_busy_cycles = 5'h03;
   typedef enum logic [2:0] {
      ugr_idle = 3'b001,
      ugr_exec = 3'b010,
      ugr_rdwait = 3'b100
   } ugr_state_e;
endpackage

// File: tb/ugr_glyph_ram_tb_top.sv
// testbench top for the glyph pattern store
`timescale 1ns/100ps
module ugr_glyph_ram_tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, two_line_mode = 1'b1, entry_increment = 1'b1;
   logic icon_enable = 1'b0, icon_blink = 1'b0, busy_and_address_read = 1'b0, scan_req = 1'b0, cursor_on = 1'b0;
   logic [7:0] scan_code = 8'h00;
   logic [2:0] scan_line = 3'h0;
   logic glyph_address_load, text_address_load, write_data, read_data, busy_flag, read_valid;
   logic scan_is_user, scan_valid;
   logic [5:0] glyph_addr_in;
   logic [6:0] text_addr_in, address_counter;
   logic [7:0] write_byte, read_byte;
   logic [4:0] icon_slots_used, scan_pixels;
   int failures = 0, compares = 0, cycles = 0;
   ugr_glyph_ram u_ugr_glyph_ram (.*);
   ugr_host_model u_ugr_host_model (.*);
   initial forever #5 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic t_address;
      u_ugr_host_model.cmd(2'h1, 8'h40);
      check({1'b0, address_counter}, 8'h40);
      u_ugr_host_model.cmd(2'h1, 8'h30);
      check({1'b0, address_counter}, 8'h40);
      u_ugr_host_model.cmd(2'h0, 8'h3f);
      check({1'b0, address_counter}, 8'h7f);
      u_ugr_host_model.cmd(2'h2, 8'ha5);
      check({1'b0, address_counter}, 8'h00);
      entry_increment = 1'b0;
      u_ugr_host_model.cmd(2'h2, 8'h11);
      check({1'b0, address_counter}, 8'h7f);
      u_ugr_host_model.cmd(2'h3, 8'h00);
      check(read_byte, 8'ha5);
      check({1'b0, address_counter}, 8'h7e);
      entry_increment = 1'b1;
      // second load arrives while busy and must be dropped
      u_ugr_host_model.issue(2'h0, 8'h05);
      u_ugr_host_model.cmd(2'h0, 8'h2a);
      check({1'b0, address_counter}, 8'h45);
      two_line_mode = 1'b0;
      u_ugr_host_model.cmd(2'h1, 8'h4f);
      check({1'b0, address_counter}, 8'h4f);
      u_ugr_host_model.cmd(2'h1, 8'h50);
      check({1'b0, address_counter}, 8'h4f);
      two_line_mode = 1'b1;
   endtask
   task automatic t_scan(input logic [7:0] code, input logic [2:0] line, input logic cur, input logic [4:0] pix);
      @(posedge clk);
      #1;
      {scan_req, scan_code, scan_line, cursor_on} = {1'b1, code, line, cur};
      @(posedge clk);
      #1;
      scan_req = 1'b0;
      scan_code = ~code;
      // scan_valid and scan_is_user stand one cycle only
      @(posedge clk);
      #1;
      check({7'h00, scan_valid}, 8'h01);
      check({7'h00, scan_is_user}, {7'h00, code[7:4] == 4'h0});
      check({3'h0, scan_pixels}, {3'h0, pix});
   endtask
   task automatic t_glyph_scan;
      t_scan(8'h0f, 3'h7, 1'b0, 5'h05);
      t_scan(8'h0f, 3'h7, 1'b1, 5'h1f);
      t_scan(8'h00, 3'h0, 1'b1, 5'h11);
      t_scan(8'h10, 3'h0, 1'b0, 5'h00);
   endtask
   task automatic t_icons;
      for (int i = 0; i < 4; i++) begin
         {icon_enable, icon_blink} = 2'(i);
         repeat (2) @(posedge clk);
         #1;
         check({3'h0, icon_slots_used}, i[1] ? (i[0] ? 8'h08 : 8'h04) : 8'h00);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_address();
      t_glyph_scan();
      t_icons();
      end_sim();
   end
endmodule // ugr_glyph_ram_tb_top

// File: tb/ugr_host_model.sv
// host side: issues address and data instructions
`timescale 1ns/100ps
module ugr_host_model (
   input wire logic clk,
   input wire logic busy_flag,
   output logic glyph_address_load = 1'b0,
   output logic [5:0] glyph_addr_in = 6'h00,
   output logic text_address_load = 1'b0,
   output logic [6:0] text_addr_in = 7'h00,
   output logic write_data = 1'b0,
   output logic [7:0] write_byte = 8'h00,
   output logic read_data = 1'b0
);
   // k: 0 glyph load, 1 text load, 2 write, 3 read
   // one-cycle pulse with no busy wait, so a caller can land a command mid-instruction
   task automatic issue(input logic [1:0] k, input logic [7:0] v);
      @(posedge clk);
      #1;
      glyph_addr_in = v[5:0];
      text_addr_in = v[6:0];
      write_byte = v;
      {read_data, write_data, text_address_load, glyph_address_load} = 4'h1 << k;
      @(posedge clk);
      #1;
      {read_data, write_data, text_address_load, glyph_address_load} = 4'h0;
      // released lines flip so a stale value is never read by luck
      {glyph_addr_in, text_addr_in, write_byte} = ~{glyph_addr_in, text_addr_in, write_byte};
   endtask
   task automatic cmd(input logic [1:0] k, input logic [7:0] v);
      issue(k, v);
      for (int i = 0; i < 8 && busy_flag !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
endmodule // ugr_host_model

// File: tb/ugr_monitor.sv
// checker: port relations of the glyph pattern store
`timescale 1ns/100ps
module ugr_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic glyph_address_load,
   input wire logic [5:0] glyph_addr_in,
   input wire logic text_address_load,
   input wire logic entry_increment,
   input wire logic write_data,
   input wire logic read_data,
   input wire logic busy_flag,
   input wire logic [6:0] address_counter,
   input wire logic read_valid,
   input wire logic icon_enable,
   input wire logic icon_blink,
   input wire logic [4:0] icon_slots_used,
   input wire logic scan_req,
   input wire logic [7:0] scan_code,
   input wire logic [2:0] scan_line,
   input wire logic cursor_on,
   input wire logic scan_is_user,
   input wire logic [4:0] scan_pixels,
   input wire logic scan_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // reads are lowest priority, so any other command hides them
   wire take = !busy_flag && (glyph_address_load || text_address_load || write_data);
   chk_busy_time:
      assert property (take |=> busy_flag [*3] ##1 !busy_flag) else $error("busy time");
   chk_addr_step:
      assert property (write_data && !busy_flag && !glyph_address_load && !text_address_load |=> address_counter ==
         7'($past(address_counter) + ($past(entry_increment) ? 7'h01 : 7'h7f))) else $error("step");
   chk_glyph_load:
      assert property (glyph_address_load && !busy_flag |=>
         address_counter == {$past(address_counter[6]), $past(glyph_addr_in)}) else $error("glyph load");
   chk_busy_hold:
      assert property (busy_flag |=> address_counter == $past(address_counter)) else $error("busy hold");
   chk_read_answer:
      assert property (read_data && !busy_flag && !take |=> !read_valid ##1 read_valid) else $error("read");
   chk_scan_time:
      assert property (scan_req && !(!busy_flag && (read_data || write_data)) |-> ##2 scan_valid)
         else $error("scan time");
   chk_scan_user:
      assert property (scan_valid |-> scan_is_user == ($past(scan_code, 2) < 8'h10)) else $error("user");
   chk_cursor_or:
      assert property (scan_valid && scan_is_user && $past(cursor_on, 2) && $past(scan_line, 2) == 3'h7 |->
         scan_pixels == 5'h1f) else $error("cursor");
   chk_icon_slots:
      assert property (1'b1 |=> icon_slots_used ==
         (!$past(icon_enable) ? 5'h00 : $past(icon_blink) ? 5'h08 : 5'h04)) else $error("icons");
endmodule // ugr_monitor
bind ugr_glyph_ram ugr_monitor u_ugr_monitor (.*);
